// ### design/ocdc_regs.svh
`ifndef OCDC_REGS_SVH
`define OCDC_REGS_SVH

// Register indices; the byte address is four times the index
`define OCDC_IDX_B_ROUTING   12'h195
`define OCDC_IDX_C_TIMING    12'h196
`define OCDC_IDX_C_CONTROL   12'h197
`define OCDC_IDX_C_ROUTING   12'h198
`define OCDC_IDX_C_STATUS    12'h199
`define OCDC_IDX_SRC_SELECT  12'h1E1
`define OCDC_ADDR_LSB        2
`define OCDC_ADDR_W          12

// Field positions
`define OCDC_RT_DIRECT_BIT   1
`define OCDC_RT_DCC_OFF_BIT  0

// Source select encodings
`define OCDC_SEL_EXT         2'h0
`define OCDC_SEL_EXT_NOPRE   2'h1
`define OCDC_SEL_OSC         2'h2

// Reset values
`define OCDC_RST_ROUTING     8'h00
`define OCDC_RST_TIMING      8'h00
`define OCDC_RST_CONTROL     8'h00
`define OCDC_RST_SRC_SELECT  2'h0

// Bus answers
`define OCDC_RESP_OKAY       2'h0
`define OCDC_RESP_SLVERR     2'h2

`endif

// ### design/ocdc_pkg.sv
package ocdc_pkg;

    typedef struct packed {
        logic       bypass;
        logic       ignore_sync;
        logic       force_high;
        logic       start_high;
        logic [3:0] phase;
    } ocdc_control_t;

    typedef struct packed {
        logic [3:0] low_count;
        logic [3:0] high_count;
    } ocdc_timing_t;

    typedef enum logic [1:0] {
        OCDC_HOLD,
        OCDC_PHASE,
        OCDC_RUN
    } ocdc_state_t;

endpackage : ocdc_pkg

// ### design/ocdc_output_divider.sv
`timescale 1ns/1ps
`include "ocdc_regs.svh"

module ocdc_output_divider (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Clock sources and sync pin
    input  wire logic        ext_clk,
    input  wire logic        sync_n,
    input  wire logic        div_b_level,
    // Output pairs
    output logic             pair_b_first_output,
    output logic             pair_b_second_output,
    output logic             pair_c_first_output,
    output logic             pair_c_second_output,
    output logic             pair_b_dcc_en,
    output logic             pair_c_dcc_en
);

    // Registers
    logic [7:0]              b_routing_q;
    logic [7:0]              c_routing_q;
    ocdc_pkg::ocdc_control_t c_control_q;
    ocdc_pkg::ocdc_timing_t  c_timing_q;
    logic [1:0]              src_sel_q;

    // Bus state
    logic                    aw_held_q;
    logic                    w_held_q;
    logic [`OCDC_ADDR_W-1:0] aw_idx_q;
    logic [7:0]              w_data_q;
    logic                    w_strb_q;

    // Source and divider state
    logic                    ext_s1_q;
    logic                    ext_s2_q;
    logic                    sync_s1_q;
    logic                    sync_s2_q;
    logic                    sync_s3_q;
    logic                    osc_level_q;
    logic                    tree_prev_q;
    logic                    tree_level;
    logic                    tree_tick;
    logic                    sync_release;
    logic                    sync_hold;
    ocdc_pkg::ocdc_state_t   state_q;
    logic [3:0]              cnt_q;
    logic                    level_q;
    logic                    div_c_q;
    logic                    div_c_d;

    function automatic logic [`OCDC_ADDR_W-1:0] to_index(input logic [31:0] addr);
        to_index = addr[`OCDC_ADDR_W+`OCDC_ADDR_LSB-1:`OCDC_ADDR_LSB];
    endfunction : to_index

    // only the two plain selections enable a direct path
    function automatic logic direct_active(input logic [7:0] rt, input logic [1:0] sel);
        direct_active = rt[`OCDC_RT_DIRECT_BIT]
            && (sel == `OCDC_SEL_OSC || sel == `OCDC_SEL_EXT);
    endfunction : direct_active

    function automatic logic route_level(input logic [7:0] rt, input logic [1:0] sel,
                                         input logic div, input logic osc,
                                         input logic ext);
        if (!direct_active(rt, sel)) begin
            route_level = div;
        end else if (sel == `OCDC_SEL_OSC) begin
            route_level = osc;
        end else begin
            route_level = ext;
        end
    endfunction : route_level

    function automatic logic mapped(input logic [`OCDC_ADDR_W-1:0] idx);
        mapped = idx == `OCDC_IDX_B_ROUTING || idx == `OCDC_IDX_C_TIMING
            || idx == `OCDC_IDX_C_CONTROL || idx == `OCDC_IDX_C_ROUTING
            || idx == `OCDC_IDX_C_STATUS || idx == `OCDC_IDX_SRC_SELECT;
    endfunction : mapped

    // Write channel: address and data taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q     <= 1'b0;
            w_held_q      <= 1'b0;
            aw_idx_q      <= '0;
            w_data_q      <= 8'h00;
            w_strb_q      <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `OCDC_RESP_OKAY;
        end else begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            if (s_axi_awvalid && !aw_held_q && !s_axi_awready && !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
                aw_held_q     <= 1'b1;
                aw_idx_q      <= to_index(s_axi_awaddr);
            end
            if (s_axi_wvalid && !w_held_q && !s_axi_wready && !s_axi_bvalid) begin
                s_axi_wready <= 1'b1;
                w_held_q     <= 1'b1;
                w_data_q     <= s_axi_wdata[7:0];
                w_strb_q     <= s_axi_wstrb[0];
            end
            if (aw_held_q && w_held_q && !s_axi_bvalid) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= mapped(aw_idx_q) ? `OCDC_RESP_OKAY : `OCDC_RESP_SLVERR;
                aw_held_q    <= 1'b0;
                w_held_q     <= 1'b0;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Register file; only byte lane 0 carries data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            b_routing_q <= `OCDC_RST_ROUTING;
            c_routing_q <= `OCDC_RST_ROUTING;
            c_control_q <= `OCDC_RST_CONTROL;
            c_timing_q  <= `OCDC_RST_TIMING;
            src_sel_q   <= `OCDC_RST_SRC_SELECT;
        end else if (aw_held_q && w_held_q && !s_axi_bvalid && w_strb_q) begin
            case (aw_idx_q)
                `OCDC_IDX_B_ROUTING:  b_routing_q <= {6'h00, w_data_q[1:0]};
                `OCDC_IDX_C_ROUTING:  c_routing_q <= {6'h00, w_data_q[1:0]};
                `OCDC_IDX_C_CONTROL:  c_control_q <= w_data_q;
                `OCDC_IDX_C_TIMING:   c_timing_q  <= w_data_q;
                `OCDC_IDX_SRC_SELECT: src_sel_q   <= w_data_q[1:0];
                default: ;
            endcase
        end
    end

    // Read channel: one cycle to the answer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `OCDC_RESP_OKAY;
        end else begin
            s_axi_arready <= 1'b0;
            if (s_axi_rvalid) begin
                if (s_axi_rready) begin
                    s_axi_rvalid <= 1'b0;
                end
            end else if (s_axi_arvalid && !s_axi_arready) begin
                s_axi_arready <= 1'b1;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= mapped(to_index(s_axi_araddr))
                    ? `OCDC_RESP_OKAY : `OCDC_RESP_SLVERR;
                case (to_index(s_axi_araddr))
                    `OCDC_IDX_B_ROUTING:  s_axi_rdata <= {24'h000000, b_routing_q};
                    `OCDC_IDX_C_ROUTING:  s_axi_rdata <= {24'h000000, c_routing_q};
                    `OCDC_IDX_C_CONTROL:  s_axi_rdata <= {24'h000000, c_control_q};
                    `OCDC_IDX_C_TIMING:   s_axi_rdata <= {24'h000000, c_timing_q};
                    `OCDC_IDX_SRC_SELECT: s_axi_rdata <= {30'h00000000, src_sel_q};
                    `OCDC_IDX_C_STATUS:   s_axi_rdata <= {24'h000000, div_c_q, level_q,
                                                          state_q, cnt_q};
                    default:              s_axi_rdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Pin synchronisers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_s1_q  <= 1'b0;
            ext_s2_q  <= 1'b0;
            sync_s1_q <= 1'b1;
            sync_s2_q <= 1'b1;
            sync_s3_q <= 1'b1;
        end else begin
            ext_s1_q  <= ext_clk;
            ext_s2_q  <= ext_s1_q;
            sync_s1_q <= sync_n;
            sync_s2_q <= sync_s1_q;
            sync_s3_q <= sync_s2_q;
        end
    end

    // Oscillator stand-in: half the system rate
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            osc_level_q <= 1'b0;
            tree_prev_q <= 1'b0;
        end else begin
            osc_level_q <= ~osc_level_q;
            tree_prev_q <= tree_level;
        end
    end

    assign tree_level   = src_sel_q[1] ? osc_level_q : ext_s2_q;
    assign tree_tick    = tree_level && !tree_prev_q;
    assign sync_hold    = !sync_s2_q && !c_control_q.ignore_sync;
    assign sync_release = sync_s2_q && !sync_s3_q && !c_control_q.ignore_sync;

    // Divider C counter and phase sequencing
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= ocdc_pkg::OCDC_PHASE;
            cnt_q   <= 4'h0;
            level_q <= 1'b0;
        end else if (sync_hold) begin
            state_q <= ocdc_pkg::OCDC_HOLD;
            cnt_q   <= 4'h0;
            level_q <= 1'b0;
        end else begin
            case (state_q)
                ocdc_pkg::OCDC_HOLD: begin
                    if (sync_release || c_control_q.ignore_sync) begin
                        state_q <= ocdc_pkg::OCDC_PHASE;
                        cnt_q   <= 4'h0;
                    end
                end
                ocdc_pkg::OCDC_PHASE: begin
                    if (tree_tick) begin
                        // offset wait, then the start level
                        if (cnt_q == c_control_q.phase) begin
                            state_q <= ocdc_pkg::OCDC_RUN;
                            level_q <= c_control_q.start_high;
                            cnt_q   <= 4'h0;
                        end else begin
                            cnt_q <= cnt_q + 4'h1;
                        end
                    end
                end
                ocdc_pkg::OCDC_RUN: begin
                    if (tree_tick) begin
                        // each phase lasts count plus one ticks
                        if (cnt_q == (level_q ? c_timing_q.high_count
                                              : c_timing_q.low_count)) begin
                            level_q <= ~level_q;
                            cnt_q   <= 4'h0;
                        end else begin
                            cnt_q <= cnt_q + 4'h1;
                        end
                    end
                end
                default: begin
                    state_q <= ocdc_pkg::OCDC_HOLD;
                    cnt_q   <= 4'h0;
                    level_q <= 1'b0;
                end
            endcase
        end
    end

    always_comb begin
        if (c_control_q.bypass) begin
            // bypass passes the input, force ignored
            div_c_d = tree_level;
        end else if (c_control_q.ignore_sync && c_control_q.force_high) begin
            div_c_d = 1'b1;
        end else if (state_q == ocdc_pkg::OCDC_RUN) begin
            div_c_d = level_q;
        end else begin
            div_c_d = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_c_q <= 1'b0;
        end else begin
            div_c_q <= div_c_d;
        end
    end

    // Output pairs and correction enables
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pair_b_first_output  <= 1'b0;
            pair_b_second_output <= 1'b0;
            pair_c_first_output  <= 1'b0;
            pair_c_second_output <= 1'b0;
            pair_b_dcc_en        <= 1'b1;
            pair_c_dcc_en        <= 1'b1;
        end else begin
            pair_b_first_output  <= route_level(b_routing_q, src_sel_q, div_b_level,
                                                osc_level_q, ext_s2_q);
            pair_b_second_output <= route_level(b_routing_q, src_sel_q, div_b_level,
                                                osc_level_q, ext_s2_q);
            pair_c_first_output  <= route_level(c_routing_q, src_sel_q, div_c_q,
                                                osc_level_q, ext_s2_q);
            pair_c_second_output <= route_level(c_routing_q, src_sel_q, div_c_q,
                                                osc_level_q, ext_s2_q);
            // correction on while bit 0 clear
            pair_b_dcc_en        <= !b_routing_q[`OCDC_RT_DCC_OFF_BIT];
            pair_c_dcc_en        <= !c_routing_q[`OCDC_RT_DCC_OFF_BIT];
        end
    end

    a_pair_b_div: assert property (@(posedge aclk) disable iff (!aresetn)
        !b_routing_q[1] |=> pair_b_first_output == $past(div_b_level))
        else $error("pair B not fed by its divider");
    a_pair_b_osc: assert property (@(posedge aclk) disable iff (!aresetn)
        b_routing_q[1] && src_sel_q == 2'h2 |=> pair_b_second_output == $past(osc_level_q))
        else $error("pair B not fed by oscillator");
    a_pair_b_ext: assert property (@(posedge aclk) disable iff (!aresetn)
        b_routing_q[1] && src_sel_q == 2'h0 |=> pair_b_first_output == $past(ext_s2_q))
        else $error("pair B not fed by external clock");
    a_pair_c_div: assert property (@(posedge aclk) disable iff (!aresetn)
        !c_routing_q[1] |=> pair_c_first_output == $past(div_c_q))
        else $error("pair C not fed by its divider");
    a_pair_c_osc: assert property (@(posedge aclk) disable iff (!aresetn)
        c_routing_q[1] && src_sel_q == 2'h2 |=> pair_c_second_output == $past(osc_level_q))
        else $error("pair C not fed by oscillator");
    a_pair_c_ext: assert property (@(posedge aclk) disable iff (!aresetn)
        c_routing_q[1] && src_sel_q == 2'h0 |=> pair_c_first_output == $past(ext_s2_q))
        else $error("pair C not fed by external clock");
    a_select_no_direct: assert property (@(posedge aclk) disable iff (!aresetn)
        src_sel_q == 2'h1 |=> pair_c_first_output == $past(div_c_q))
        else $error("direct path active with select 01b");
    a_dcc_follow: assert property (@(posedge aclk) disable iff (!aresetn)
        ##1 pair_c_dcc_en == !$past(c_routing_q[0]))
        else $error("correction enable wrong");
    a_bypass_pass: assert property (@(posedge aclk) disable iff (!aresetn)
        c_control_q.bypass |=> div_c_q == $past(tree_level))
        else $error("bypass does not pass input");
    a_force_high: assert property (@(posedge aclk) disable iff (!aresetn)
        c_control_q[7:5] == 3'h3 |=> div_c_q)
        else $error("forced high missing");
    a_sync_hold_low: assert property (@(posedge aclk) disable iff (!aresetn)
        !sync_s2_q && c_control_q[7:5] == 3'h0 |=> ##1 !div_c_q)
        else $error("output not low while sync held");
    a_run_low_len: assert property (@(posedge aclk) disable iff (!aresetn)
        state_q == ocdc_pkg::OCDC_RUN && !level_q && tree_tick && !sync_hold
            && cnt_q != c_timing_q.low_count |=> !level_q)
        else $error("low phase ended early");

endmodule : ocdc_output_divider

// ### bench/tb_top.sv
`timescale 1ns/1ps
`include "ocdc_regs.svh"

module tb_top;
    logic        aclk, aresetn, ext_clk, sync_n, div_b_level;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    logic        pb1, pb2, pc1, pc2, dcc_b, dcc_c;
    int          error_cnt, tests_run;
    logic [31:0] rd;
    logic [1:0]  rs;
    int          n, hi, lo, t0, t1;
    ocdc_pkg::ocdc_timing_t tm;

    ocdc_output_divider dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .ext_clk(ext_clk), .sync_n(sync_n),
        .div_b_level(div_b_level), .pair_b_first_output(pb1),
        .pair_b_second_output(pb2), .pair_c_first_output(pc1),
        .pair_c_second_output(pc2), .pair_b_dcc_en(dcc_b), .pair_c_dcc_en(dcc_c)
    );

    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : conclude

    task automatic chk_val(input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : chk_val

    task automatic chk_flag(input bit ok);
        chk_val(32'h1, {31'h0, ok});
    endtask : chk_flag

    task automatic tmo;
        error_cnt++;
        $display("[ERR] t=%0t exp=%h got=%h", $time, 32'h1, 32'h0);
        conclude();
    endtask : tmo

    function automatic int run_exp(input logic [3:0] cnt);
        // Oscillator ticks the divider every second bus clock
        return (int'(cnt) + 1) * 2;
    endfunction : run_exp

    function automatic logic pout(input bit pc);
        return pc ? pc1 : pb1;
    endfunction : pout

    task automatic axi_wr(input logic [11:0] idx, input logic [7:0] val,
                          input logic [3:0] strb, output logic [1:0] resp);
        int k;
        @(posedge aclk);
        s_axi_awaddr  <= {18'h0, idx, 2'h0};
        s_axi_wdata   <= {8'h00, 8'($urandom), 8'h00, val};
        s_axi_wstrb   <= strb;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        k = 0;
        do begin
            @(posedge aclk);
            k++;
            if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
            if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && k < 50);
        if (k >= 50) tmo();
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [11:0] idx, output logic [31:0] data,
                          output logic [1:0] resp);
        int k;
        @(posedge aclk);
        s_axi_araddr  <= {18'h0, idx, 2'h0};
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        k = 0;
        do begin
            @(posedge aclk);
            k++;
            if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && k < 50);
        if (k >= 50) tmo();
        data = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready  <= 1'b0;
    endtask : axi_rd

    task automatic wr(input logic [11:0] idx, input logic [7:0] val);
        axi_wr(idx, val, 4'hF, rs);
        chk_val(`OCDC_RESP_OKAY, rs);
    endtask : wr

    task automatic count_chg(input bit pc, input int cyc, output int cnt);
        logic prev;
        prev = pout(pc);
        cnt = 0;
        repeat (cyc) begin
            @(posedge aclk);
            if (pout(pc) !== prev) cnt++;
            prev = pout(pc);
        end
    endtask : count_chg

    // Output must settle to a static level, both pins alike
    task automatic settle(input bit pc, input logic lvl);
        repeat (8) @(posedge aclk);
        count_chg(pc, 12, n);
        chk_val(0, n);
        chk_val({31'h0, lvl}, {31'h0, pout(pc)});
        chk_val({31'h0, pout(pc)}, {31'h0, pc ? pc2 : pb2});
    endtask : settle

    task automatic wait_lvl(input logic lvl, output int cnt);
        cnt = 0;
        do begin
            @(posedge aclk);
            cnt++;
        end while (pc1 !== lvl && cnt < 300);
        if (cnt >= 300) tmo();
    endtask : wait_lvl

    task automatic end_test(input string name);
        $display("test %s finished, mismatches so far %0d", name, error_cnt);
    endtask : end_test

    task automatic sync_start(input logic [7:0] ctl, output int dly);
        @(posedge aclk);
        sync_n <= 1'b0;
        wr(`OCDC_IDX_C_CONTROL, ctl);
        settle(1, 1'b0);              // held low
        @(posedge aclk);
        sync_n <= 1'b1;
        wait_lvl(1'b1, dly);
    endtask : sync_start

    initial begin
        static logic [11:0] idx [5] = '{`OCDC_IDX_B_ROUTING, `OCDC_IDX_C_TIMING,
            `OCDC_IDX_C_CONTROL, `OCDC_IDX_C_ROUTING, `OCDC_IDX_SRC_SELECT};
        static logic [7:0]  msk [5] = '{8'h03, 8'hFF, 8'hFF, 8'h03, 8'h03};
        logic [7:0]  v;
        error_cnt = 0;
        tests_run = 0;
        void'($urandom(32'hE6A4FE4B));
        {aresetn, sync_n, ext_clk, div_b_level} = 4'h4;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = '0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (idx[i]) begin
            axi_rd(idx[i], rd, rs);
            chk_val(32'h0, rd);       // reset values
        end
        chk_val(32'h3, {30'h0, dcc_b, dcc_c}); // correction on
        end_test("reset");
        axi_rd(12'h100, rd, rs);
        chk_val({30'h0, `OCDC_RESP_SLVERR}, {30'h0, rs});
        chk_val(32'h0, rd);
        axi_wr(12'h100, 8'h5A, 4'hF, rs);
        chk_val({30'h0, `OCDC_RESP_SLVERR}, {30'h0, rs});
        for (int r = 0; r < 3; r++) begin
            foreach (idx[i]) begin
                v = (r == 0) ? 8'hFF : 8'($urandom);
                if (idx[i] == `OCDC_IDX_SRC_SELECT && v[1:0] == 2'h3) v[1:0] = 2'h2;
                wr(idx[i], v);
                axi_rd(idx[i], rd, rs);
                chk_val({24'h0, v & msk[i]}, rd);
            end
        end
        foreach (idx[i]) wr(idx[i], 8'h00);
        // Lane 0 strobe low: answered but not written
        axi_wr(`OCDC_IDX_C_TIMING, 8'hA5, 4'hE, rs);
        chk_val(`OCDC_RESP_OKAY, rs);
        axi_rd(`OCDC_IDX_C_TIMING, rd, rs);
        chk_val(32'h0, rd);
        end_test("registers");
        wr(`OCDC_IDX_B_ROUTING, 8'h01);
        wr(`OCDC_IDX_C_ROUTING, 8'h01);
        @(posedge aclk);
        chk_val(32'h0, {30'h0, dcc_b, dcc_c}); // correction off
        end_test("duty");
        for (int i = 0; i < 8; i++) begin
            wr(`OCDC_IDX_SRC_SELECT, (i % 2) ? `OCDC_SEL_OSC : `OCDC_SEL_EXT);
            wr(`OCDC_IDX_B_ROUTING, 8'h00);
            @(posedge aclk);
            v[0] = 1'($urandom);
            div_b_level <= v[0];
            settle(0, v[0]);          // divider feeds pair B
        end
        wr(`OCDC_IDX_SRC_SELECT, `OCDC_SEL_EXT_NOPRE);
        wr(`OCDC_IDX_B_ROUTING, 8'h02);
        settle(0, div_b_level);       // direct bit ignored
        wr(`OCDC_IDX_C_CONTROL, 8'h60);
        for (int s = 0; s < 2; s++) begin
            wr(`OCDC_IDX_C_ROUTING, {6'h0, s[0], 1'b0});
            settle(1, 1'b1);          // divider feeds pair C
        end
        wr(`OCDC_IDX_SRC_SELECT, `OCDC_SEL_EXT);
        for (int p = 0; p < 2; p++) begin
            wr(p ? `OCDC_IDX_C_ROUTING : `OCDC_IDX_B_ROUTING, 8'h02);
            for (int k = 0; k < 4; k++) begin
                @(posedge aclk);
                ext_clk <= k[0];
                settle(p[0], k[0]);   // external clock direct
            end
        end
        wr(`OCDC_IDX_SRC_SELECT, `OCDC_SEL_OSC);
        repeat (2) @(posedge aclk);
        for (int p = 0; p < 2; p++) begin
            count_chg(p[0], 16, n);
            chk_val(16, n);           // oscillator direct
        end
        wr(`OCDC_IDX_B_ROUTING, 8'h00);
        wr(`OCDC_IDX_C_ROUTING, 8'h00);
        end_test("routing");
        wr(`OCDC_IDX_C_CONTROL, 8'hE0);
        repeat (4) @(posedge aclk);
        count_chg(1, 16, n);
        chk_val(16, n);               // bypass passes input
        wr(`OCDC_IDX_C_CONTROL, 8'h00);
        for (int i = 0; i < 6; i++) begin
            tm = 8'($urandom);
            if (i == 0) tm = 8'h00;
            if (i == 1) tm = 8'hFF;
            wr(`OCDC_IDX_C_TIMING, tm);
            wait_lvl(1'b0, n);
            wait_lvl(1'b1, n);
            wait_lvl(1'b0, hi);
            wait_lvl(1'b1, lo);
            chk_val(run_exp(tm.high_count), hi); // high phase
            chk_val(run_exp(tm.low_count), lo);  // low phase
        end
        end_test("divider");
        wr(`OCDC_IDX_C_TIMING, 8'h00);
        @(posedge aclk);
        sync_n <= 1'b0;
        wr(`OCDC_IDX_C_CONTROL, 8'h20);
        settle(1, 1'b0);              // force without ignore
        wr(`OCDC_IDX_C_CONTROL, 8'h40);
        repeat (8) @(posedge aclk);
        count_chg(1, 16, n);
        chk_flag(n >= 7);             // ignoring sync keeps running
        @(posedge aclk);
        sync_n <= 1'b1;
        end_test("sync");
        wr(`OCDC_IDX_C_TIMING, 8'hFF);
        sync_start(8'h10, t0);
        chk_flag(t0 <= 14);           // start high
        sync_start(8'h14, t1);
        chk_flag(t1 - t0 >= 7 && t1 - t0 <= 9); // phase offset of four
        sync_start(8'h00, t1);
        chk_flag(t1 >= run_exp(4'hF)); // start low
        end_test("start");
        conclude();
    end
endmodule : tb_top
